// File: hw/acctr_pkg.sv
// package of opcodes, widths and carrier types for the transfer decoder
package acctr_pkg;
	// ===========================================================
	// widths
	localparam int ACCTR_OP_W   = 10;
	localparam int ACCTR_NIB_W  = 4;
	localparam int ACCTR_PAGE_W = 3;
	localparam int ACCTR_PAIR_W = 8;
	localparam int ACCTR_NCFG   = 4;
	localparam int ACCTR_NDST   = 9;

	// ===========================================================
	// opcodes (10-bit)
	localparam logic [9:0] OP_ACC_TO_AUX      = 10'h00e;
	localparam logic [9:0] OP_ACC_TO_PAGE     = 10'h029;
	localparam logic [9:0] OP_ACC_AUX_TO_PAIR = 10'h01a;
	localparam logic [9:0] OP_ACC_TO_CFG0     = 10'h228;
	localparam logic [9:0] OP_ACC_TO_CFG1     = 10'h229;
	localparam logic [9:0] OP_ACC_TO_CFG2     = 10'h22a;
	localparam logic [9:0] OP_ACC_TO_CFG3     = 10'h22b;
	localparam logic [9:0] OP_ACC_TO_IRQ1     = 10'h217;

	// ===========================================================
	// destination select indices
	localparam int DST_AUX  = 0;
	localparam int DST_PAGE = 1;
	localparam int DST_PAIR = 2;
	localparam int DST_CFG0 = 3;
	localparam int DST_IRQ1 = 7;

	// ===========================================================
	// reset values
	localparam logic [3:0] RST_NIB  = 4'h0;
	localparam logic [2:0] RST_PAGE = 3'h0;
	localparam logic [7:0] RST_PAIR = 8'h00;

	// field positions
	localparam int PAIR_HI_LSB = 4;

	// ===========================================================
	// carrier for the instruction issue
	typedef struct packed {
		logic       valid;
		logic [9:0] opcode;
	} acctr_issue_s;

	// carrier for the destination register state
	typedef struct packed {
		logic [3:0]  aux;
		logic [2:0]  page;
		logic [7:0]  pair;
		logic [15:0] port_cfg;
		logic [3:0]  irq_ctrl_one;
	} acctr_regs_s;
endpackage : acctr_pkg

// File: hw/acctr_nib_reg.sv
// one clock-enabled write-enabled register with reset value
`timescale 1ns/10ps
module acctr_nib_reg #(
	parameter int               W   = 4,
	parameter logic [W-1:0]     RST = '0
) (
	input  wire logic         clk_sys_i,
	input  wire logic         sys_rst_i,
	input  wire logic         ce_i,
	input  wire logic         we_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	// ===========================================================
	// storage
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			q_o <= RST;
		else if (ce_i && we_i)
			q_o <= d_i;
	end
endmodule : acctr_nib_reg

// File: hw/acctr_core.sv
// decoder and destination registers of accumulator transfer instructions
`timescale 1ns/10ps
// Notes on behaviour
// - aux transfer copies all four accumulator bits to aux, one cycle.
// - page transfer loads page from accumulator bits 2..0, ignores bit 3.
// - pair transfer writes aux into pair bits 7..4.
// - same pair transfer writes accumulator into pair bits 3..0.
// - first port config transfer copies accumulator to port config zero.
// - third and fourth copy accumulator to port config two and three.
// - interrupt transfer copies accumulator into interrupt control one.
module acctr_core (
	input  wire logic                   clk_sys_i,
	input  wire logic                   sys_rst_i,
	input  wire logic                   ce_i,
	input  wire acctr_pkg::acctr_issue_s issue_i,
	input  wire logic [3:0]             acc_i,
	input  wire logic                   carry_flag_i,
	output acctr_pkg::acctr_regs_s      regs_o,
	output logic [8:0]                  dst_we_o,
	output logic                        hit_o,
	output logic                        skip_o,
	output logic                        carry_flag_o,
	output logic                        done_o
);
	import acctr_pkg::*;

	// ===========================================================
	// opcode decode
	// one-hot destination of an opcode, all zero when it is not ours
	function automatic logic [8:0] dec_dst(input logic [9:0] op);
		logic [8:0] r;
		r = '0;
		case (op)
			OP_ACC_TO_AUX:      r[DST_AUX]      = 1'b1;
			OP_ACC_TO_PAGE:     r[DST_PAGE]     = 1'b1;
			OP_ACC_AUX_TO_PAIR: r[DST_PAIR]     = 1'b1;
			OP_ACC_TO_CFG0:     r[DST_CFG0]     = 1'b1;
			OP_ACC_TO_CFG1:     r[DST_CFG0 + 1] = 1'b1;
			OP_ACC_TO_CFG2:     r[DST_CFG0 + 2] = 1'b1;
			OP_ACC_TO_CFG3:     r[DST_CFG0 + 3] = 1'b1;
			OP_ACC_TO_IRQ1:     r[DST_IRQ1]     = 1'b1;
			default:            r               = '0; // other groups
		endcase
		return r;
	endfunction : dec_dst

	// ===========================================================
	// issue qualification
	logic       exec_go;
	logic [8:0] dec_hit;

	// an issue counts only while valid and with the clock enabled
	assign exec_go = issue_i.valid & ce_i;
	assign dec_hit = dec_dst(issue_i.opcode);

	// ===========================================================
	// write enables
	// unknown opcodes, idle and frozen cycles write nothing
	// bit 8 is spare and stays low
	assign dst_we_o = exec_go ? dec_hit : '0;
	assign hit_o    = |dst_we_o;

	// ===========================================================
	// per-destination enables
	logic                  we_aux;
	logic                  we_page;
	logic                  we_pair;
	logic [ACCTR_NCFG-1:0] we_cfg;
	logic                  we_irq_one;

	// named slices of the one-hot vector
	assign we_aux     = dst_we_o[DST_AUX];
	assign we_page    = dst_we_o[DST_PAGE];
	assign we_pair    = dst_we_o[DST_PAIR];
	assign we_cfg     = dst_we_o[DST_CFG0 +: ACCTR_NCFG];
	assign we_irq_one = dst_we_o[DST_IRQ1];

	// ===========================================================
	// flags
	// these instructions never skip and leave carry alone
	// carry passes straight through, so no cycle is added
	assign skip_o       = 1'b0;
	assign carry_flag_o = carry_flag_i;

	// ===========================================================
	// register contents
	// nets, so the four configuration nibbles may be driven apart
	wire logic [ACCTR_NIB_W-1:0]            cur_aux;
	wire logic [ACCTR_PAGE_W-1:0]           cur_page;
	wire logic [ACCTR_PAIR_W-1:0]           cur_pair;
	wire logic [ACCTR_NCFG*ACCTR_NIB_W-1:0] cur_port_cfg;
	wire logic [ACCTR_NIB_W-1:0]            cur_irq_one;

	// gather the registers into the output carrier
	assign regs_o = '{
		aux:          cur_aux,
		page:         cur_page,
		pair:         cur_pair,
		port_cfg:     cur_port_cfg,
		irq_ctrl_one: cur_irq_one
	};

	// ===========================================================
	// write data
	// every destination loads at the same edge as its enable, so
	// nothing here may depend on a value written in this cycle
	logic [ACCTR_NIB_W-1:0]  next_aux;
	logic [ACCTR_PAGE_W-1:0] next_page;
	logic [ACCTR_PAIR_W-1:0] next_pair;
	logic [ACCTR_NIB_W-1:0]  next_cfg;
	logic [ACCTR_NIB_W-1:0]  next_irq_one;

	// nibble destinations take the whole accumulator
	assign next_aux     = acc_i;
	assign next_cfg     = acc_i;
	assign next_irq_one = acc_i;

	// page drops accumulator bit 3
	assign next_page    = acc_i[ACCTR_PAGE_W-1:0];

	// pair: aux as held before this edge on top, accumulator below
	assign next_pair    = {cur_aux, acc_i};

	// ===========================================================
	// auxiliary nibble register
	// written only by the aux transfer
	acctr_nib_reg #(
		.W   (ACCTR_NIB_W),
		.RST (RST_NIB)
	) u_aux (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.we_i      (we_aux),
		.d_i       (next_aux),
		.q_o       (cur_aux)
	);

	// ===========================================================
	// page register
	// three bits wide, the accumulator's top bit is lost
	acctr_nib_reg #(
		.W   (ACCTR_PAGE_W),
		.RST (RST_PAGE)
	) u_page (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.we_i      (we_page),
		.d_i       (next_page),
		.q_o       (cur_page)
	);

	// ===========================================================
	// pair register
	// both halves load together in one cycle
	acctr_nib_reg #(
		.W   (ACCTR_PAIR_W),
		.RST (RST_PAIR)
	) u_pair (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.we_i      (we_pair),
		.d_i       (next_pair),
		.q_o       (cur_pair)
	);

	// ===========================================================
	// port output-structure control registers
	// register n sits at nibble n of the packed configuration word
	genvar g;
	generate
		for (g = 0; g < ACCTR_NCFG; g++) begin : g_cfg
			localparam int LSB = g * ACCTR_NIB_W;
			acctr_nib_reg #(
				.W   (ACCTR_NIB_W),
				.RST (RST_NIB)
			) u_cfg (
				.clk_sys_i (clk_sys_i),
				.sys_rst_i (sys_rst_i),
				.ce_i      (ce_i),
				.we_i      (we_cfg[g]),
				.d_i       (next_cfg),
				.q_o       (cur_port_cfg[LSB +: ACCTR_NIB_W])
			);
		end
	endgenerate

	// ===========================================================
	// interrupt control register one
	// written only by the interrupt control transfer
	acctr_nib_reg #(
		.W   (ACCTR_NIB_W),
		.RST (RST_NIB)
	) u_irq1 (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.we_i      (we_irq_one),
		.d_i       (next_irq_one),
		.q_o       (cur_irq_one)
	);

	// ===========================================================
	// completion marker
	// done follows an executed transfer by one cycle; ce low holds it
	logic next_done;
	assign next_done = ce_i ? hit_o : done_o;

	// done register
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			done_o <= 1'b0;
		else
			done_o <= next_done;
	end
endmodule : acctr_core

// File: dv/acctr_core_assertions.sv
// concurrent checks on the ports of the transfer decoder
`timescale 1ns/10ps
module acctr_core_assertions import acctr_pkg::*; (
	input wire logic         clk_sys_i,
	input wire logic         sys_rst_i,
	input wire logic         ce_i,
	input wire logic         carry_flag_i,
	input wire acctr_issue_s issue_i,
	input wire logic [3:0]   acc_i,
	input wire acctr_regs_s  regs_o,
	input wire logic [8:0]   dst_we_o,
	input wire logic         hit_o,
	input wire logic         skip_o,
	input wire logic         carry_flag_o,
	input wire logic         done_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// an accepted transfer of a given opcode
	sequence s_go(logic [9:0] op);
		ce_i && issue_i.valid && issue_i.opcode == op;
	endsequence
	property p_aux; s_go(OP_ACC_TO_AUX) |=> regs_o.aux == $past(acc_i);
	endproperty
	a_aux: assert property (p_aux) else $error("aux wrong");
	property p_page; s_go(OP_ACC_TO_PAGE) |=> regs_o.page == 3'($past(acc_i));
	endproperty
	a_page: assert property (p_page) else $error("page wrong");
	property p_pair; s_go(OP_ACC_AUX_TO_PAIR)
		|=> regs_o.pair == {$past(regs_o.aux), $past(acc_i)}; endproperty
	a_pair: assert property (p_pair) else $error("pair wrong");
	property p_cfg0; s_go(OP_ACC_TO_CFG0)
		|=> regs_o.port_cfg[3:0] == $past(acc_i); endproperty
	a_cfg0: assert property (p_cfg0) else $error("cfg0 wrong");
	property p_cfg1; s_go(OP_ACC_TO_CFG1)
		|=> regs_o.port_cfg[7:4] == $past(acc_i); endproperty
	a_cfg1: assert property (p_cfg1) else $error("cfg1 wrong");
	property p_cfg2; s_go(OP_ACC_TO_CFG2)
		|=> regs_o.port_cfg[11:8] == $past(acc_i); endproperty
	a_cfg2: assert property (p_cfg2) else $error("cfg2 wrong");
	property p_cfg3; s_go(OP_ACC_TO_CFG3)
		|=> regs_o.port_cfg[15:12] == $past(acc_i); endproperty
	a_cfg3: assert property (p_cfg3) else $error("cfg3 wrong");
	property p_irq; s_go(OP_ACC_TO_IRQ1) |=> regs_o.irq_ctrl_one == $past(acc_i);
	endproperty
	a_irq: assert property (p_irq) else $error("irq wrong");
	property p_one; $onehot0(dst_we_o) && hit_o == (dst_we_o != 9'h0); endproperty
	a_one: assert property (p_one) else $error("enables wrong");
	property p_cy; carry_flag_o == carry_flag_i && !skip_o; endproperty
	a_cy: assert property (p_cy) else $error("carry or skip");
	// completion one cycle after a write, and a stopped clock freezes state
	property p_done; ce_i |=> done_o == $past(hit_o); endproperty
	a_done: assert property (p_done) else $error("done wrong");
	property p_hold; !ce_i |=> $stable(regs_o) && $stable(done_o); endproperty
	a_hold: assert property (p_hold) else $error("state moved");
endmodule : acctr_core_assertions
bind acctr_core acctr_core_assertions u_chk (.*);

// File: dv/tb_acctr_core.sv
// self-checking bench for the transfer decoder
`timescale 1ns/10ps
module tb_acctr_core;
	import acctr_pkg::*;
	logic         clk_sys_i = 0, sys_rst_i = 1, ce_i = 0, carry_flag_i = 0;
	logic [3:0]   acc_i = '0;
	acctr_issue_s issue_i = '0;
	acctr_regs_s  regs_o, exp = '0;
	logic [8:0]   dst_we_o;
	logic         hit_o, skip_o, carry_flag_o, done_o;
	int           fails = 0, n_compared = 0;
	logic         exp_done = 1'b0;
	logic [9:0]   ops [8] = '{OP_ACC_TO_AUX, OP_ACC_TO_PAGE, OP_ACC_AUX_TO_PAIR,
		OP_ACC_TO_CFG0, OP_ACC_TO_CFG1, OP_ACC_TO_CFG2, OP_ACC_TO_CFG3,
		OP_ACC_TO_IRQ1};
	always #5 clk_sys_i = ~clk_sys_i;
	acctr_core DUT (
		.clk_sys_i    (clk_sys_i),
		.sys_rst_i    (sys_rst_i),
		.ce_i         (ce_i),
		.issue_i      (issue_i),
		.acc_i        (acc_i),
		.carry_flag_i (carry_flag_i),
		.regs_o       (regs_o),
		.dst_we_o     (dst_we_o),
		.hit_o        (hit_o),
		.skip_o       (skip_o),
		.carry_flag_o (carry_flag_o),
		.done_o       (done_o)
	);
	// compare and count
	task automatic check(string nm, logic [63:0] seen, logic [63:0] ev);
		n_compared++;
		if (seen !== ev) begin
			fails++;
			$display("MISMATCH %s exp %h seen %h", nm, ev, seen);
		end
	endtask : check
	// issue one instruction (index 8 = unknown opcode), then check result
	task automatic exec(int k, logic [3:0] a, logic c);
		issue_i = '{1'b1, (k < 8) ? ops[k] : 10'h3ff};
		acc_i = a;
		ce_i = c;
		carry_flag_i = a[0];
		#1 check("we", dst_we_o, (c && k < 8) ? 9'(1 << k) : 9'h0);
		check("cy", {skip_o, carry_flag_o}, {1'b0, a[0]});
		check("hit", hit_o, c && k < 8);
		if (c) case (k)
			0: exp.aux = a;
			1: exp.page = a[2:0];
			2: exp.pair = {exp.aux, a};
			3, 4, 5, 6: exp.port_cfg[4*(k-3)+:4] = a;
			7: exp.irq_ctrl_one = a;
			default: ;
		endcase
		if (c) exp_done = (k < 8);
		@(posedge clk_sys_i) #1;
		check("regs", regs_o, exp);
		check("done", done_o, exp_done);
	endtask : exec
	// verdict and end of run
	task automatic test_done;
		if (fails == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	// back-to-back transfers, unknown opcode, clock enable low
	initial begin
		repeat (16) @(posedge clk_sys_i);
		#1 sys_rst_i = 0;
		check("rst", regs_o, 32'h0);
		for (int k = 0; k < 8; k++) exec(k, 4'hd - 4'(k), 1);
		exec(1, 4'h7, 0);
		exec(8, 4'h3, 1);
		exec(0, 4'h6, 0);
		exec(2, 4'h9, 1);
		// reset in mid-run clears every register and the done marker
		sys_rst_i = 1;
		ce_i = 0;
		issue_i.valid = 0;
		#1 check("mid rst", regs_o, 64'h0);
		check("mid done", done_o, 1'b0);
		repeat (2) @(posedge clk_sys_i);
		#1 sys_rst_i = 0;
		exp = '0;
		exp_done = 1'b0;
		for (int k = 7; k >= 0; k--) exec(k, 4'(k) ^ 4'ha, 1);
		issue_i.valid = 0;
		test_done;
	end
endmodule : tb_acctr_core
